// file: rtl/ao_buf_pkg.sv
// Constants, register map and carrier types for the output sample buffer.
// Assumes a single 100 MHz clock domain and a simple host register port.
// Overview of operation
// - Samples are 20 bits, offset binary or two's complement
// - Host sample writes taken only while buffer open
// - Flush bit empties buffer, count returns to zero
// - Write into full buffer dropped, overrun flag set
// - Write into closed buffer sets closed-write loss flag
// - Both loss flags sticky until host clears
// - Empty and full status bits track contents
// - Read-only fill count in low 19 bits
// - Threshold flag when count strictly above threshold
// - Open mode drops each word once output
// - Circular mode recirculates words, blocks host writes
// - Frame-end marker travels with last frame word
// - Closed continuous mode repeats contents while clocked
// - Triggered burst plays one frame, stops at marker
// - Successive triggers play successive frames in order
// - Append request granted at frame start, buffer opens
// - Old frame end closes buffer, clears grant, request
// - Writes after grant interval set closed-write loss flag
// - Hardware output clocks pass only when enabled and sourced
// - Clock-ready low during reset work and calibration
// - Grant rises at frame index zero; resets high
// - Flush and append request bits self-clear
// - One 32-bit write-only data port, bit 20 marks end
// - Buffer holds 256 K words shared by channels

package ao_buf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_BCR = 8'h00;
  localparam logic [7:0] OFS_OPS = 8'h04;
  localparam logic [7:0] OFS_THRESH = 8'h40;
  localparam logic [7:0] OFS_LEVEL = 8'h44;
  localparam logic [7:0] OFS_DATA = 8'h48;

  // Buffered operations register bit positions
  localparam int OPS_CLK_EN = 5;
  localparam int OPS_CLK_RDY = 6;
  localparam int OPS_SW_CLK = 7;
  localparam int OPS_CIRC = 8;
  localparam int OPS_LOAD_REQ = 9;
  localparam int OPS_LOAD_RDY = 10;
  localparam int OPS_CLEAR = 11;
  localparam int OPS_EMPTY = 12;
  localparam int OPS_THR = 13;
  localparam int OPS_FULL = 15;
  localparam int OPS_OVR = 16;
  localparam int OPS_FOVR = 17;
  localparam int OPS_BURST_RDY = 18;
  localparam int OPS_BURST_EN = 19;
  localparam int OPS_SW_TRIG = 20;

  // Board control register bit positions and reset value
  localparam int BCR_OFFSET_BIN = 4;
  localparam int BCR_SIMUL = 5;
  localparam logic [31:0] BCR_RESET = 32'h0000_0010;

  // Sample format
  localparam int DATA_W = 20;
  localparam int EOF_BIT = 20;
  localparam int THR_FLAG_BIT = 20;
  localparam int LEVEL_W = 19;
  localparam int DEPTH = 262144;
  localparam logic [LEVEL_W-1:0] THRESH_RESET = 19'h3FFFE;
  localparam logic [DATA_W-1:0] SIGN_FLIP = 20'h80000;

  // One stored sample: frame-end marker plus value
  typedef struct packed {
    logic eof;
    logic [DATA_W-1:0] data;
  } sample_s;

  // One word presented to the converter channels
  typedef struct packed {
    logic [3:0] chan;
    logic eof;
    logic [DATA_W-1:0] data;
  } dac_s;

endpackage

// file: rtl/two_entry_buffer.sv
// Two-entry valid/ready buffer between sample memory and converter side.
// Assumes both sides are on clk_sys; clear drops all held words.
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter int W = 21
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // Number of held words
  output logic [1:0] occupancy
);

  // Entries and fill count
  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0] cnt;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic push;
  logic pop;

  // Handshakes straight from the count; data from flops
  assign in_ready = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data = s_q.e0;
  assign occupancy = s_q.cnt;

  // Next state: entry 0 is always the oldest word
  always_comb
  begin
    s_d = s_q;
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    if (clear)
    begin
      // Flush wins over any transfer this cycle
      s_d.cnt = 2'h0;
    end
    else if (push && pop)
    begin
      // Count unchanged; shift and refill
      if (s_q.cnt == 2'h1)
        s_d.e0 = in_data;
      else
      begin
        s_d.e0 = s_q.e1;
        s_d.e1 = in_data;
      end
    end
    else if (pop)
    begin
      s_d.e0 = s_q.e1;
      s_d.cnt = s_q.cnt - 2'h1;
    end
    else if (push)
    begin
      if (s_q.cnt == 2'h0)
        s_d.e0 = in_data;
      else
        s_d.e1 = in_data;
      s_d.cnt = s_q.cnt + 2'h1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule // two_entry_buffer

`default_nettype wire

// file: rtl/analog_output_sample_buffer.sv
// Sample buffer feeding the output converter channels: memory, modes,
// frame bursts, append handshake, output clock gating and host registers.
// Assumes clock ticks, triggers and busy levels come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module analog_output_sample_buffer #(
  parameter int DEPTH = ao_buf_pkg::DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host register port
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // Clocking and trigger sources
  input wire logic clk_tick,
  input wire logic clk_src_en,
  input wire logic hw_trigger,
  input wire logic init_busy,
  input wire logic cal_busy,
  input wire logic [4:0] active_count,
  // Converter side
  output ao_buf_pkg::dac_s dac_word,
  output logic dac_load,
  output logic dac_update
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  // Whole control state of the block
  typedef struct packed {
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [CW-1:0] count;
    logic [ao_buf_pkg::LEVEL_W-1:0] thresh;
    logic offset_bin;
    logic simul;
    logic clk_en;
    logic circ;
    logic load_req;
    logic load_rdy;
    logic clear;
    logic ovr;
    logic fovr;
    logic burst_en;
    logic sw_trig;
    logic sw_clk;
    logic appending;
    logic frame_start;
    logic burst_act;
    logic [4:0] left;
    logic [3:0] chan;
    ao_buf_pkg::dac_s dac;
    logic dac_load;
    logic dac_update;
    logic [31:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  // Sample store; holds the whole shared capacity
  ao_buf_pkg::sample_s mem [DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_wa;
  ao_buf_pkg::sample_s mem_wd;

  // Memory to converter side path
  ao_buf_pkg::sample_s head;
  ao_buf_pkg::sample_s skid_out;
  logic skid_in_valid;
  logic skid_in_ready;
  logic skid_out_valid;
  logic skid_out_ready;
  logic [1:0] skid_cnt;

  // Combinational helpers
  logic busy;
  logic clk_ready;
  logic tick;
  logic can_run;
  logic grant_now;
  logic open_now;
  logic recirc;
  logic fetch;
  logic pop;
  logic host_push;
  logic data_wr;
  logic ops_wr;
  logic [CW-1:0] level;
  logic full;
  logic empty;
  logic thr_flag;
  logic [31:0] ops_view;

  assign head = mem[s_q.rd_ptr];

  // Holds prefetched words so a converter stall loses nothing
  two_entry_buffer #(
    .W($bits(ao_buf_pkg::sample_s))
  ) i_two_entry_buffer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(s_q.clear),
    .in_valid(skid_in_valid),
    .in_ready(skid_in_ready),
    .in_data(head),
    .out_valid(skid_out_valid),
    .out_ready(skid_out_ready),
    .out_data(skid_out),
    .occupancy(skid_cnt)
  );

  // Status derived from the current state
  always_comb
  begin
    // Recirculated copies already sit in memory, so the skid adds nothing then
    level = s_q.count + ((s_q.circ && !s_q.appending) ? CW'(0) : CW'(skid_cnt));
    full = (s_q.count == FULL_COUNT);
    empty = (level == CW'(0));
    thr_flag = (32'(level) > 32'(s_q.thresh));
    busy = init_busy | cal_busy;
    clk_ready = s_q.clk_en & clk_src_en & ~busy;
    ops_view = 32'h0000_0000;
    ops_view[ao_buf_pkg::OPS_CLK_EN] = s_q.clk_en;
    ops_view[ao_buf_pkg::OPS_CLK_RDY] = clk_ready;
    ops_view[ao_buf_pkg::OPS_SW_CLK] = s_q.sw_clk;
    ops_view[ao_buf_pkg::OPS_CIRC] = s_q.circ;
    ops_view[ao_buf_pkg::OPS_LOAD_REQ] = s_q.load_req;
    ops_view[ao_buf_pkg::OPS_LOAD_RDY] = s_q.load_rdy;
    ops_view[ao_buf_pkg::OPS_CLEAR] = s_q.clear;
    ops_view[ao_buf_pkg::OPS_EMPTY] = empty;
    ops_view[ao_buf_pkg::OPS_THR] = thr_flag;
    ops_view[ao_buf_pkg::OPS_FULL] = full;
    ops_view[ao_buf_pkg::OPS_OVR] = s_q.ovr;
    ops_view[ao_buf_pkg::OPS_FOVR] = s_q.fovr;
    ops_view[ao_buf_pkg::OPS_BURST_RDY] = s_q.burst_en & ~s_q.burst_act;
    ops_view[ao_buf_pkg::OPS_BURST_EN] = s_q.burst_en;
    ops_view[ao_buf_pkg::OPS_SW_TRIG] = s_q.sw_trig;
  end

  // Datapath handshakes and the append decision
  always_comb
  begin
    // Software clock ignores the source selection but not busy phases
    tick = (clk_tick & clk_ready) | (s_q.sw_clk & ~busy);
    can_run = ~s_q.burst_en | s_q.burst_act;
    // Open the loop at the first word of a frame
    grant_now = s_q.circ & s_q.load_req & ~s_q.appending & s_q.frame_start;
    // Host may write when open, or inside the grant interval
    open_now = ~s_q.circ | s_q.appending;
    recirc = s_q.circ & ~s_q.appending & ~grant_now;
    // Prefetch only while clocking runs, so words loaded idle recirculate when closed
    skid_in_valid = (s_q.count != CW'(0)) & ~s_q.clear & (s_q.clk_en | (s_q.left != 5'h00));
    fetch = skid_in_valid & skid_in_ready;
    skid_out_ready = (s_q.left != 5'h00) & can_run & ~s_q.clear;
    pop = skid_out_ready & skid_out_valid;
    data_wr = bus_wr & (bus_addr == ao_buf_pkg::OFS_DATA);
    ops_wr = bus_wr & (bus_addr == ao_buf_pkg::OFS_OPS);
    host_push = data_wr & open_now & ~full & ~s_q.clear;
    // Host and recirculation writes never coincide: recirc implies closed
    mem_we = host_push | (fetch & recirc);
    mem_wa = s_q.wr_ptr;
    if (host_push)
      mem_wd = ao_buf_pkg::sample_s'(bus_wdata[ao_buf_pkg::EOF_BIT:0]);
    else
      mem_wd = head;
  end

  // Memory write port; contents need no reset
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // Next state of all control, pointers and registers
  always_comb
  begin
    s_d = s_q;
    s_d.dac_load = 1'b0;
    s_d.dac_update = 1'b0;
    s_d.sw_clk = 1'b0;
    s_d.clear = 1'b0;

    // Register writes from the host
    if (bus_wr && bus_addr == ao_buf_pkg::OFS_BCR)
    begin
      s_d.offset_bin = bus_wdata[ao_buf_pkg::BCR_OFFSET_BIN];
      s_d.simul = bus_wdata[ao_buf_pkg::BCR_SIMUL];
    end
    if (bus_wr && bus_addr == ao_buf_pkg::OFS_THRESH)
      s_d.thresh = bus_wdata[ao_buf_pkg::LEVEL_W-1:0];
    if (ops_wr)
    begin
      s_d.clk_en = bus_wdata[ao_buf_pkg::OPS_CLK_EN];
      s_d.sw_clk = bus_wdata[ao_buf_pkg::OPS_SW_CLK];
      s_d.circ = bus_wdata[ao_buf_pkg::OPS_CIRC];
      s_d.load_req = bus_wdata[ao_buf_pkg::OPS_LOAD_REQ];
      s_d.clear = bus_wdata[ao_buf_pkg::OPS_CLEAR];
      s_d.burst_en = bus_wdata[ao_buf_pkg::OPS_BURST_EN];
      s_d.sw_trig = s_q.sw_trig | bus_wdata[ao_buf_pkg::OPS_SW_TRIG];
      // Loss flags: writing low clears, writing high does nothing
      s_d.ovr = s_q.ovr & bus_wdata[ao_buf_pkg::OPS_OVR];
      s_d.fovr = s_q.fovr & bus_wdata[ao_buf_pkg::OPS_FOVR];
    end

    // Data port writes: refused when closed, dropped when full
    if (data_wr && !open_now)
      s_d.fovr = 1'b1;
    else if (data_wr && full)
      s_d.ovr = 1'b1;
    if (host_push)
      s_d.wr_ptr = s_q.wr_ptr + AW'(1);

    // Memory head moves to the skid; recirculate or discard it
    if (fetch)
    begin
      s_d.rd_ptr = s_q.rd_ptr + AW'(1);
      s_d.frame_start = head.eof;
      if (recirc)
        s_d.wr_ptr = s_q.wr_ptr + AW'(1);
    end
    s_d.count = s_q.count + CW'(host_push) - CW'(fetch & ~recirc);

    // Append handshake: open at frame start, close at old frame end
    if (grant_now)
    begin
      s_d.appending = 1'b1;
      s_d.load_rdy = 1'b1;
    end
    if (fetch && head.eof && (s_q.appending || grant_now))
    begin
      s_d.appending = 1'b0;
      s_d.load_rdy = 1'b0;
      s_d.load_req = 1'b0;
    end

    // Burst start on software or hardware trigger
    if (s_q.burst_en && !s_q.burst_act && (hw_trigger || s_q.sw_trig))
      s_d.burst_act = 1'b1;
    // Burst also ends when nothing is left to play
    if (s_q.burst_act && empty)
    begin
      s_d.burst_act = 1'b0;
      s_d.sw_trig = 1'b0;
    end

    // Accepted clock: one word sequentially, a whole group simultaneously
    if (tick && can_run && s_q.left == 5'h00)
      s_d.left = s_q.simul ? active_count : 5'h01;

    // Move one word to the converter side
    if (pop)
    begin
      s_d.dac.data = s_q.offset_bin ? skid_out.data : (skid_out.data ^ ao_buf_pkg::SIGN_FLIP);
      s_d.dac.eof = skid_out.eof;
      s_d.dac.chan = s_q.chan;
      s_d.dac_load = 1'b1;
      s_d.left = s_q.left - 5'h01;
      s_d.dac_update = ~s_q.simul | (s_q.left == 5'h01);
      if ({1'b0, s_q.chan} >= active_count - 5'h01)
        s_d.chan = 4'h0;
      else
        s_d.chan = s_q.chan + 4'h1;
      // Marker stops a burst; continuous clocking ignores it
      if (s_q.burst_en && skid_out.eof)
      begin
        s_d.burst_act = 1'b0;
        s_d.sw_trig = 1'b0;
        s_d.left = 5'h00;
        s_d.dac_update = 1'b1;
        s_d.chan = 4'h0;
      end
    end

    // Flush: drop memory and skid contents, restart frame tracking
    if (s_q.clear)
    begin
      s_d.rd_ptr = '0;
      s_d.wr_ptr = '0;
      s_d.count = '0;
      s_d.frame_start = 1'b1;
      s_d.appending = 1'b0;
      s_d.left = 5'h00;
      s_d.chan = 4'h0;
      s_d.burst_act = 1'b0;
    end

    // Registered read data; unmapped and data port read zero
    if (bus_rd)
    begin
      unique case (bus_addr)
        ao_buf_pkg::OFS_BCR:
          s_d.rdata = (32'(s_q.offset_bin) << ao_buf_pkg::BCR_OFFSET_BIN)
                    | (32'(s_q.simul) << ao_buf_pkg::BCR_SIMUL);
        ao_buf_pkg::OFS_OPS:
          s_d.rdata = ops_view;
        ao_buf_pkg::OFS_THRESH:
          s_d.rdata = 32'(s_q.thresh) | (32'(thr_flag) << ao_buf_pkg::THR_FLAG_BIT);
        ao_buf_pkg::OFS_LEVEL:
          s_d.rdata = 32'(level);
        default:
          s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.thresh <= ao_buf_pkg::THRESH_RESET;
      s_q.offset_bin <= ao_buf_pkg::BCR_RESET[ao_buf_pkg::BCR_OFFSET_BIN];
      s_q.load_rdy <= 1'b1;
      s_q.frame_start <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flops
  assign bus_rdata = s_q.rdata;
  assign dac_word = s_q.dac;
  assign dac_load = s_q.dac_load;
  assign dac_update = s_q.dac_update;

endmodule // analog_output_sample_buffer

`default_nettype wire

// file: verification/analog_output_sample_buffer_monitor.sv
// Checker for the sample buffer: register port answers and converter pulses.
// Assumes it is bound to the top module; one clk_sys domain, resetn async.
`timescale 1ns/1ps
`default_nettype none

module analog_output_sample_buffer_monitor #(
  parameter int DEPTH = ao_buf_pkg::DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host register port
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  // Clocking and trigger sources
  input wire logic clk_tick,
  input wire logic clk_src_en,
  input wire logic hw_trigger,
  input wire logic init_busy,
  input wire logic cal_busy,
  input wire logic [4:0] active_count,
  // Converter side
  input wire ao_buf_pkg::dac_s dac_word,
  input wire logic dac_load,
  input wire logic dac_update
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Read strobe taken at one register
  sequence s_rd(logic [7:0] a);
    bus_rd && bus_addr == a;
  endsequence

  // Flush command taken, then one cycle without writes
  sequence s_flush;
    bus_wr && bus_addr == ao_buf_pkg::OFS_OPS && bus_wdata[ao_buf_pkg::OPS_CLEAR] ##1 !bus_wr;
  endsequence

  a_update_has_load: assert property (dac_update |-> dac_load)
    else $error("update pulse without load pulse");
  a_data_port_zero: assert property (s_rd(ao_buf_pkg::OFS_DATA) |=> bus_rdata == 32'h00000000)
    else $error("data port read not zero");
  a_level_upper_zero: assert property (s_rd(ao_buf_pkg::OFS_LEVEL) |=> bus_rdata[31:19] == 13'h0000)
    else $error("fill count upper bits set");
  a_thresh_reserved: assert property (s_rd(ao_buf_pkg::OFS_THRESH) |=> !bus_rdata[19] && bus_rdata[31:21] == 11'h000)
    else $error("threshold reserved bits set");
  a_thresh_not_empty: assert property (s_rd(ao_buf_pkg::OFS_OPS) |=> !(bus_rdata[13] && bus_rdata[12]))
    else $error("threshold flag while empty");
  a_empty_not_full: assert property (s_rd(ao_buf_pkg::OFS_OPS) |=> !(bus_rdata[12] && bus_rdata[15]))
    else $error("empty and full together");
  a_busy_no_ready: assert property ((init_busy || cal_busy) [*2] ##0 s_rd(ao_buf_pkg::OFS_OPS) |=> !bus_rdata[6])
    else $error("clock ready while busy");
  a_flush_level: assert property (s_flush ##1 s_rd(ao_buf_pkg::OFS_LEVEL) |=> bus_rdata[18:0] == 19'h00000)
    else $error("fill count not zero after flush");
  a_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (bus_rd && !(bus_addr inside {8'h00, 8'h04, 8'h40, 8'h44}) |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // analog_output_sample_buffer_monitor

bind analog_output_sample_buffer analog_output_sample_buffer_monitor #(.DEPTH(DEPTH)) i_monitor (
  .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .clk_tick(clk_tick), .clk_src_en(clk_src_en),
  .hw_trigger(hw_trigger), .init_busy(init_busy), .cal_busy(cal_busy), .active_count(active_count),
  .dac_word(dac_word), .dac_load(dac_load), .dac_update(dac_update));

`default_nettype wire

// file: verification/host_bus_model.sv
// Host processor model: one-cycle register writes, reads and sample writes.
// Assumes the strobe port of the sample buffer, all on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [31:0] bus_rdata
);
  // Idle port at time zero
  initial
  begin
    bus_addr = 8'h00;
    bus_wdata = 32'h00000000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // One write; data is scrambled after the strobe so nothing stale lingers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask

  // One read; answer is taken at the edge after the taking edge, where it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(posedge clk_sys);
    d = bus_rdata;
  endtask

  // One sample as one 32-bit write, marker in bit 20, in caller's order
  task automatic put(input logic [19:0] v, input logic eof);
    wr(ao_buf_pkg::OFS_DATA, {11'h000, eof, v});
  endtask
endmodule // host_bus_model

`default_nettype wire

// file: verification/analog_output_sample_buffer_test.sv
// Self-checking bench for the sample buffer with a queue model of contents.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none

module analog_output_sample_buffer_test;
  localparam int DEPTH = 16; // Small depth keeps fill tests short
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic clk_tick = 1'b0;
  logic clk_src_en = 1'b0;
  logic hw_trigger = 1'b0;
  logic init_busy = 1'b0;
  logic cal_busy = 1'b0;
  logic [4:0] active_count = 5'h01;
  ao_buf_pkg::dac_s dac_word;
  logic dac_load;
  logic dac_update;
  int errors = 0;
  int n_compared = 0;
  int seed;
  logic [31:0] got_q[$]; // Update flag and word seen at the converter
  logic [31:0] exp_q[$]; // Update flag and word the model predicts
  logic [19:0] mq[$]; // Model of stored samples

  always #5 clk_sys = ~clk_sys;

  analog_output_sample_buffer #(.DEPTH(DEPTH)) i_analog_output_sample_buffer (
    .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .clk_tick(clk_tick), .clk_src_en(clk_src_en),
    .hw_trigger(hw_trigger), .init_busy(init_busy), .cal_busy(cal_busy), .active_count(active_count),
    .dac_word(dac_word), .dac_load(dac_load), .dac_update(dac_update));

  host_bus_model i_host_bus_model (
    .clk_sys(clk_sys), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  // Collect every word handed to the converter
  always @(posedge clk_sys)
    if (dac_load === 1'b1)
      got_q.push_back({6'h00, dac_update, dac_word});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    i_host_bus_model.rd(a, d);
    chk(d & m, e);
  endtask

  // Output clock pulses, spaced so each finishes before the next
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      clk_tick <= 1'b1;
      @(posedge clk_sys);
      clk_tick <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  task automatic outs_chk();
    repeat (3) @(posedge clk_sys);
    chk(32'(got_q.size()), 32'(exp_q.size()));
    while (got_q.size() > 0 && exp_q.size() > 0)
      chk(got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    logic [31:0] v;
    logic [31:0] d;
    logic [19:0] fr[3];
    logic [19:0] nf[4];
    int ac;
    logic full;
    seed = 34;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    rdchk(ao_buf_pkg::OFS_THRESH, 32'hFFFFFFFF, 32'h0003FFFE);
    rdchk(ao_buf_pkg::OFS_LEVEL, 32'hFFFFFFFF, 32'h00000000);
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00039400, 32'h00001400);
    rdchk(ao_buf_pkg::OFS_DATA, 32'hFFFFFFFF, 32'h00000000);
    rdchk(8'h7C, 32'hFFFFFFFF, 32'h00000000);
    $display("test reset done");
    // Fill until full, tracking count and threshold at every word
    i_host_bus_model.wr(ao_buf_pkg::OFS_THRESH, 32'h00000005);
    full = 1'b0;
    for (int i = 0; i < DEPTH + 3 && !full; i++)
    begin
      v = $random(seed);
      i_host_bus_model.put(v[19:0], 1'b0);
      mq.push_back(v[19:0]);
      rdchk(ao_buf_pkg::OFS_LEVEL, 32'h0007FFFF, 32'(mq.size()));
      rdchk(ao_buf_pkg::OFS_THRESH, 32'h00100000, (mq.size() > 5) ? 32'h00100000 : 32'h0);
      i_host_bus_model.rd(ao_buf_pkg::OFS_OPS, d);
      full = d[ao_buf_pkg::OPS_FULL];
    end
    chk({31'h0, full}, 32'h1);
    chk({31'h0, mq.size() >= DEPTH}, 32'h1);
    i_host_bus_model.put(20'hABCDE, 1'b0);
    rdchk(ao_buf_pkg::OFS_LEVEL, 32'h0007FFFF, 32'(mq.size()));
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00010000, 32'h00010000);
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00000000);
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00010000, 32'h00000000);
    $display("test fill done");
    // Drain in open mode, two's complement input, random channel count
    i_host_bus_model.wr(ao_buf_pkg::OFS_BCR, 32'h00000000);
    ac = 1 + ({$random(seed)} % 16);
    active_count <= 5'(ac);
    tick(2);
    chk(32'(got_q.size()), 32'h0);
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00000020);
    clk_src_en <= 1'b1;
    init_busy <= 1'b1;
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00000040, 32'h00000000);
    init_busy <= 1'b0;
    cal_busy <= 1'b1;
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00000040, 32'h00000000);
    cal_busy <= 1'b0;
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00000040, 32'h00000040);
    for (int k = 0; mq.size() > 0; k++)
      exp_q.push_back({6'h00, 1'b1, 4'(k % ac), 1'b0, mq.pop_front() ^ ao_buf_pkg::SIGN_FLIP});
    tick(exp_q.size());
    outs_chk();
    rdchk(ao_buf_pkg::OFS_LEVEL, 32'hFFFFFFFF, 32'h00000000);
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00001000, 32'h00001000);
    $display("test drain done");
    // Flush with clocking off
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00000000);
    repeat (3) i_host_bus_model.put(20'h12345, 1'b0);
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00000800);
    rdchk(ao_buf_pkg::OFS_LEVEL, 32'hFFFFFFFF, 32'h00000000);
    $display("test flush done");
    // One frame, then closed: rejected write, bursts, continuous replay
    for (int k = 0; k < 3; k++)
    begin
      v = $random(seed);
      fr[k] = v[19:0];
      i_host_bus_model.put(fr[k], k == 2);
    end
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00000100);
    i_host_bus_model.rd(ao_buf_pkg::OFS_LEVEL, d);
    i_host_bus_model.put(20'h55555, 1'b1);
    rdchk(ao_buf_pkg::OFS_LEVEL, 32'hFFFFFFFF, d);
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00020000, 32'h00020000);
    active_count <= 5'h04;
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00080120);
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00020000, 32'h00000000);
    repeat (2)
    begin
      @(posedge clk_sys);
      hw_trigger <= 1'b1;
      @(posedge clk_sys);
      hw_trigger <= 1'b0;
      tick(5);
      for (int k = 0; k < 3; k++)
        exp_q.push_back({6'h00, 1'b1, 4'(k), k == 2, fr[k] ^ ao_buf_pkg::SIGN_FLIP});
    end
    outs_chk();
    // Continuous replay, then whole groups per clock with one update each
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00000120);
    tick(8);
    i_host_bus_model.wr(ao_buf_pkg::OFS_BCR, 32'h00000020);
    tick(2);
    for (int k = 0; k < 16; k++)
      exp_q.push_back({6'h00, k < 8 || k % 4 == 3, 4'(k % 4), (k % 3) == 2, fr[k % 3] ^ ao_buf_pkg::SIGN_FLIP});
    outs_chk();
    $display("test circular done");
    // Append a four-word frame to the running loop, then write once too late
    i_host_bus_model.wr(ao_buf_pkg::OFS_OPS, 32'h00000320);
    for (int k = 0; k < 4; k++)
    begin
      v = $random(seed);
      nf[k] = v[19:0];
      i_host_bus_model.put(nf[k], k == 3);
    end
    tick(3);
    for (int k = 0; k < 12; k++)
      exp_q.push_back({6'h00, k % 4 == 3, 4'(k % 4), (k < 5 ? k % 3 == 1 : k % 4 == 0),
                       (k < 5 ? fr[(k + 1) % 3] : nf[(k + 3) % 4]) ^ ao_buf_pkg::SIGN_FLIP});
    outs_chk();
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00000600, 32'h00000000);
    i_host_bus_model.put(20'hAAAAA, 1'b0);
    rdchk(ao_buf_pkg::OFS_OPS, 32'h00020000, 32'h00020000);
    $display("test append done");
    complete_run();
  end
endmodule // analog_output_sample_buffer_test

`default_nettype wire
